// [verilog/bpc_regs.sv]
`timescale 1ns/1ns
module bpc_regs (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [bpc_pkg::PITCH_W-1:0] SRC_PITCH,
  output logic [bpc_pkg::PITCH_W-1:0] DST_PITCH,
  output bpc_pkg::bpc_fmt_t PIXEL_FORMAT,
  output logic [31:0] FG_COLOR,
  output logic [31:0] BG_COLOR
);
  import bpc_pkg::*;

  bpc_reg_if rif ();

  logic [PITCH_W-1:0] src_pitch_r;
  logic [PITCH_W-1:0] dst_pitch_r;
  logic [31:0] fg_r;
  logic [31:0] bg_r;
  bpc_fmt_t fmt_r;
  logic [31:0] fg_eff_r;
  logic [31:0] bg_eff_r;

  // only whole-word transfers are used, so size is not decoded
  bpc_ahb u_ahb (
    .clk(CORE_CLK),
    .srst(SRST),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hrdata(HRDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .rif(rif.bus)
  );

  wire sel_src = rif.addr == SRC_PITCH_ADDR;
  wire sel_dst = rif.addr == DST_PITCH_ADDR;
  wire sel_fg = rif.addr == FG_COLOR_ADDR;
  wire sel_bg = rif.addr == BG_COLOR_ADDR;
  wire sel_fmt = rif.addr == FMT_SEL_ADDR;
  wire sel_fg_eff = rif.addr == FG_EFF_ADDR;
  wire sel_bg_eff = rif.addr == BG_EFF_ADDR;
  wire [1:0] fmt_wdata = rif.wdata[FMT_MSB:FMT_LSB];

  // colour layout mask chosen by the pixel format code
  wire [31:0] fmt_mask = (fmt_r == FMT_8) ? MASK_8 :
                         (fmt_r == FMT_16) ? MASK_16 :
                         (fmt_r == FMT_24) ? MASK_24 :
                         MASK_32;
  wire [31:0] fg_eff_nxt = fg_r & fmt_mask;
  wire [31:0] bg_eff_nxt = bg_r & fmt_mask;

  wire [31:0] fmt_rdata = {26'h0, fmt_r, 4'h0};
  // unmapped addresses read as zero and ignore writes
  assign rif.rdata = sel_src ? {20'h0, src_pitch_r} :
                     sel_dst ? {20'h0, dst_pitch_r} :
                     sel_fg ? fg_r :
                     sel_bg ? bg_r :
                     sel_fmt ? fmt_rdata :
                     sel_fg_eff ? fg_eff_r :
                     sel_bg_eff ? bg_eff_r :
                     32'h0000_0000;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      src_pitch_r <= PITCH_RST;
      dst_pitch_r <= PITCH_RST;
    end else begin
      src_pitch_r <= (rif.wr && sel_src) ? rif.wdata[PITCH_W-1:0] : src_pitch_r;
      dst_pitch_r <= (rif.wr && sel_dst) ? rif.wdata[PITCH_W-1:0] : dst_pitch_r;
    end
  end

  // raw colour words are kept whole: the format may change after they are loaded
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      fg_r <= COLOR_RST;
      bg_r <= COLOR_RST;
      fmt_r <= FMT_RST;
    end else begin
      fg_r <= (rif.wr && sel_fg) ? rif.wdata : fg_r;
      bg_r <= (rif.wr && sel_bg) ? rif.wdata : bg_r;
      fmt_r <= (rif.wr && sel_fmt) ? bpc_fmt_t'(fmt_wdata) : fmt_r;
    end
  end

  // interpreted colours lag the raw words by one clock
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      fg_eff_r <= COLOR_RST;
      bg_eff_r <= COLOR_RST;
    end else begin
      fg_eff_r <= fg_eff_nxt;
      bg_eff_r <= bg_eff_nxt;
    end
  end

  assign SRC_PITCH = src_pitch_r;
  assign DST_PITCH = dst_pitch_r;
  assign PIXEL_FORMAT = fmt_r;
  assign FG_COLOR = fg_eff_r;
  assign BG_COLOR = bg_eff_r;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  src_pitch_wr_a: assert property (
    rif.wr && sel_src |=> SRC_PITCH == $past(rif.wdata[PITCH_W-1:0]))
    else $error("source pitch not loaded from write data");
  dst_pitch_wr_a: assert property (
    rif.wr && sel_dst |=> DST_PITCH == $past(rif.wdata[PITCH_W-1:0]) && $stable(SRC_PITCH))
    else $error("destination pitch not loaded or source pitch disturbed");
  fg_index_a: assert property (
    fmt_r == FMT_8 |=> FG_COLOR == {24'h0, $past(fg_r[7:0])})
    else $error("foreground 8-bit index layout wrong");
  fg_word16_a: assert property (
    fmt_r == FMT_16 |=> FG_COLOR[31:16] == 16'h0 && FG_COLOR[15:8] == $past(fg_r[15:8]) &&
      FG_COLOR[7:0] == $past(fg_r[7:0]))
    else $error("foreground 16-bit layout wrong");
  bg_index_a: assert property (
    fmt_r == FMT_8 |=> BG_COLOR == {24'h0, $past(bg_r[7:0])})
    else $error("background 8-bit index layout wrong");
  bg_word16_a: assert property (
    fmt_r == FMT_16 ##1 fmt_r == FMT_16 |=> BG_COLOR[31:16] == 16'h0 && BG_COLOR[15:0] == $past(bg_r[15:0]))
    else $error("background 16-bit layout wrong");
  fmt_full32_a: assert property (
    rif.wr && sel_fmt && fmt_wdata == 2'b10 ##1 fmt_r == FMT_32 |=> FG_COLOR == $past(fg_r) &&
      BG_COLOR == $past(bg_r))
    else $error("32-bit format does not pass the whole colour word");
  rgb_layout_a: assert property (
    fmt_r == FMT_24 |=> FG_COLOR[31:24] == 8'h00 && BG_COLOR[31:24] == 8'h00 &&
      FG_COLOR[23:0] == $past(fg_r[23:0]) && BG_COLOR[23:0] == $past(bg_r[23:0]))
    else $error("24-bit colour layout wrong");
  read_wait_a: assert property (
    HSEL && HREADY && HTRANS[1] && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read does not take exactly one wait state");

  // a stray decode would silently corrupt a neighbour, so every writable register must hold between its own writes
  src_pitch_hold_a: assert property (
    !(rif.wr && sel_src) |=> $stable(SRC_PITCH))
    else $error("source pitch changed without a write");
  dst_pitch_hold_a: assert property (
    !(rif.wr && sel_dst) |=> $stable(DST_PITCH))
    else $error("destination pitch changed without a write");
  fg_hold_a: assert property (
    !(rif.wr && sel_fg) |=> $stable(fg_r))
    else $error("foreground word changed without a write");
  bg_hold_a: assert property (
    !(rif.wr && sel_bg) |=> $stable(bg_r))
    else $error("background word changed without a write");
  fmt_hold_a: assert property (
    !(rif.wr && sel_fmt) |=> $stable(PIXEL_FORMAT))
    else $error("pixel format changed without a write");

  // raw colour words keep every bit; the format only masks the outputs
  fg_load_a: assert property (
    rif.wr && sel_fg |=> fg_r == $past(rif.wdata))
    else $error("foreground word not loaded from write data");
  bg_load_a: assert property (
    rif.wr && sel_bg |=> bg_r == $past(rif.wdata))
    else $error("background word not loaded from write data");
  fmt_load_a: assert property (
    rif.wr && sel_fmt |=> PIXEL_FORMAT == $past(fmt_wdata))
    else $error("pixel format not loaded from its field");
  full_word_a: assert property (
    fmt_r == FMT_32 |=> FG_COLOR == $past(fg_r) && BG_COLOR == $past(bg_r))
    else $error("32-bit format does not keep the whole colour words");

  // reserved pitch bits and unmapped places read as zero
  src_read_zero_a: assert property (
    sel_src |-> rif.rdata[31:PITCH_W] == 20'h0_0000)
    else $error("source pitch reserved bits read non-zero");
  dst_read_zero_a: assert property (
    sel_dst |-> rif.rdata[31:PITCH_W] == 20'h0_0000)
    else $error("destination pitch reserved bits read non-zero");
  fmt_read_a: assert property (
    sel_fmt |-> rif.rdata[FMT_MSB:FMT_LSB] == PIXEL_FORMAT && rif.rdata[31:FMT_MSB+1] == 26'h0 &&
      rif.rdata[FMT_LSB-1:0] == 4'h0)
    else $error("format register read-back wrong");
  fg_eff_read_a: assert property (
    sel_fg_eff |-> rif.rdata == FG_COLOR)
    else $error("effective foreground read-back differs from output");
  bg_eff_read_a: assert property (
    sel_bg_eff |-> rif.rdata == BG_COLOR)
    else $error("effective background read-back differs from output");
  unmapped_read_a: assert property (
    !(sel_src || sel_dst || sel_fg || sel_bg || sel_fmt || sel_fg_eff || sel_bg_eff) |-> rif.rdata == 32'h0000_0000)
    else $error("unmapped address reads non-zero");

  // writes take no wait state; read data stands until the wait state of the next read ends
  write_no_wait_a: assert property (
    HSEL && HREADY && HTRANS[1] && HWRITE |=> HREADYOUT)
    else $error("write inserted a wait state");
  read_data_a: assert property (
    !HREADYOUT |=> HRDATA == $past(rif.rdata))
    else $error("read data not taken from the addressed register");
  rdata_hold_a: assert property (
    HREADYOUT |=> $stable(HRDATA))
    else $error("read data changed outside a read");
endmodule : bpc_regs

// [verilog/bpc_pkg.sv]
package bpc_pkg;
  // printed offsets are word indices; byte address is four times the index
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] SRC_PITCH_IDX = 8'h10;
  localparam logic [ADDR_W-1:0] DST_PITCH_IDX = 8'h12;
  localparam logic [ADDR_W-1:0] FG_COLOR_IDX = 8'h14;
  localparam logic [ADDR_W-1:0] BG_COLOR_IDX = 8'h18;
  localparam logic [ADDR_W-1:0] FMT_SEL_IDX = 8'h1e;
  localparam logic [ADDR_W-1:0] FG_EFF_IDX = 8'h20;
  localparam logic [ADDR_W-1:0] BG_EFF_IDX = 8'h21;
  localparam logic [ADDR_W-1:0] SRC_PITCH_ADDR = SRC_PITCH_IDX << 2;
  localparam logic [ADDR_W-1:0] DST_PITCH_ADDR = DST_PITCH_IDX << 2;
  localparam logic [ADDR_W-1:0] FG_COLOR_ADDR = FG_COLOR_IDX << 2;
  localparam logic [ADDR_W-1:0] BG_COLOR_ADDR = BG_COLOR_IDX << 2;
  localparam logic [ADDR_W-1:0] FMT_SEL_ADDR = FMT_SEL_IDX << 2;
  localparam logic [ADDR_W-1:0] FG_EFF_ADDR = FG_EFF_IDX << 2;
  localparam logic [ADDR_W-1:0] BG_EFF_ADDR = BG_EFF_IDX << 2;

  localparam int PITCH_W = 12;
  localparam int FMT_LSB = 4;
  localparam int FMT_MSB = 5;

  typedef enum logic [1:0] {
    FMT_8 = 2'b00,
    FMT_16 = 2'b01,
    FMT_32 = 2'b10,
    FMT_24 = 2'b11
  } bpc_fmt_t;

  localparam logic [31:0] MASK_8 = 32'h0000_00ff;
  localparam logic [31:0] MASK_16 = 32'h0000_ffff;
  localparam logic [31:0] MASK_24 = 32'h00ff_ffff;
  localparam logic [31:0] MASK_32 = 32'hffff_ffff;

  // power-on contents are undefined in the engine; zero is chosen
  localparam logic [PITCH_W-1:0] PITCH_RST = 12'h000;
  localparam logic [31:0] COLOR_RST = 32'h0000_0000;
  localparam bpc_fmt_t FMT_RST = FMT_8;
endpackage : bpc_pkg

// [verilog/bpc_reg_if.sv]
`timescale 1ns/1ns
interface bpc_reg_if;
  import bpc_pkg::*;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus (output wr, output addr, output wdata, input rdata);
  modport regs (input wr, input addr, input wdata, output rdata);
endinterface : bpc_reg_if

// [verilog/bpc_ahb.sv]
`timescale 1ns/1ns
module bpc_ahb (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  bpc_reg_if.bus rif
);
  import bpc_pkg::*;

  logic wr_pend_r;
  logic rd_pend_r;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;

  wire addr_ph = hsel && hready && htrans[1];
  wire rd_start = addr_ph && !hwrite;

  // one wait state on reads so that a write just before lands first
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= '0;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
    end else begin
      wr_pend_r <= addr_ph && hwrite;
      rd_pend_r <= rd_start;
      addr_r <= addr_ph ? haddr[ADDR_W-1:0] : addr_r;
      hrdata_r <= rd_pend_r ? rif.rdata : hrdata_r;
      hreadyout_r <= !rd_start;
    end
  end

  assign rif.wr = wr_pend_r;
  assign rif.addr = addr_r;
  assign rif.wdata = hwdata;
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
endmodule : bpc_ahb

// [tb/blit_pitch_and_color_regs_bench.sv]
`timescale 1ns/1ns
module blit_pitch_and_color_regs_bench;
  import bpc_pkg::*;
  logic CORE_CLK = 1'b0;
  logic SRST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0000_0000;
  logic [1:0] HTRANS = 2'b00;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'b010;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic [PITCH_W-1:0] SRC_PITCH;
  logic [PITCH_W-1:0] DST_PITCH;
  bpc_fmt_t PIXEL_FORMAT;
  logic [31:0] FG_COLOR;
  logic [31:0] BG_COLOR;
  int errors = 0;
  int checked = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  // single slave: its own ready is the bus ready
  bpc_regs dut (.CORE_CLK(CORE_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRC_PITCH(SRC_PITCH), .DST_PITCH(DST_PITCH),
    .PIXEL_FORMAT(PIXEL_FORMAT), .FG_COLOR(FG_COLOR), .BG_COLOR(BG_COLOR));

  task automatic conclude;
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // hready is sampled in the edge's active region, before the slave's own updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge CORE_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {24'h00_0000, a};
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
    chk("hresp", 32'h0000_0000, {31'h0, HRESP});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(what, exp, r);
  endtask : rd_chk

  // colour outputs lag the register by one clock
  task automatic settle;
    repeat (2) @(posedge CORE_CLK);
    #1;
  endtask : settle

  task automatic reset_values;
    rd_chk("src pitch reset", SRC_PITCH_ADDR, 32'h0000_0000);
    chk("fg out reset", 32'h0000_0000, FG_COLOR);
  endtask : reset_values

  task automatic pitch_fields;
    wr(SRC_PITCH_ADDR, 32'hffff_ffff);
    wr(DST_PITCH_ADDR, 32'h0000_a5c3);
    rd_chk("src pitch", SRC_PITCH_ADDR, 32'h0000_0fff);
    rd_chk("dst pitch", DST_PITCH_ADDR, 32'h0000_05c3);
    settle;
    chk("src pitch out", 32'h0000_0fff, {20'h0, SRC_PITCH});
    chk("dst pitch out", 32'h0000_05c3, {20'h0, DST_PITCH});
    // packed 24-bit rows of 200 pixels
    wr(SRC_PITCH_ADDR, 32'h0000_0258);
    wr(DST_PITCH_ADDR, 32'h0000_0258);
    rd_chk("src pitch x3", SRC_PITCH_ADDR, 32'h0000_0258);
    rd_chk("dst pitch x3", DST_PITCH_ADDR, 32'h0000_0258);
  endtask : pitch_fields

  task automatic colour_formats;
    logic [31:0] fg;
    logic [31:0] m;
    fg = 32'hdead_beef;
    wr(FG_COLOR_ADDR, fg);
    wr(BG_COLOR_ADDR, ~fg);
    rd_chk("fg raw", FG_COLOR_ADDR, fg);
    rd_chk("bg raw", BG_COLOR_ADDR, ~fg);
    for (int f = 0; f < 4; f++) begin
      m = (f == 0) ? 32'h0000_00ff : (f == 1) ? 32'h0000_ffff : (f == 2) ? 32'hffff_ffff : 32'h00ff_ffff;
      wr(FMT_SEL_ADDR, 32'(f) << 4);
      settle;
      chk("format", 32'(f), {30'h0, PIXEL_FORMAT});
      chk("fg out", fg & m, FG_COLOR);
      chk("bg out", ~fg & m, BG_COLOR);
      rd_chk("fg eff", FG_EFF_ADDR, fg & m);
      rd_chk("bg eff", BG_EFF_ADDR, ~fg & m);
    end
  endtask : colour_formats

  task automatic refused_places;
    wr(8'h0c, 32'hffff_ffff);
    rd_chk("unmapped", 8'h0c, 32'h0000_0000);
    wr(FMT_SEL_ADDR, 32'hffff_ffff);
    rd_chk("format reserved", FMT_SEL_ADDR, 32'h0000_0030);
  endtask : refused_places

  // a reset in mid-run must clear what the earlier scenarios loaded
  task automatic reset_again;
    SRST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    SRST <= 1'b0;
    #1;
    chk("src pitch mid reset", {20'h0, PITCH_RST}, {20'h0, SRC_PITCH});
    chk("dst pitch mid reset", {20'h0, PITCH_RST}, {20'h0, DST_PITCH});
    chk("format mid reset", {30'h0, FMT_RST}, {30'h0, PIXEL_FORMAT});
    chk("fg out mid reset", COLOR_RST, FG_COLOR);
    chk("bg out mid reset", COLOR_RST, BG_COLOR);
    chk("hrdata mid reset", 32'h0000_0000, HRDATA);
    chk("hreadyout mid reset", 32'h0000_0001, {31'h0, HREADYOUT});
    rd_chk("bg raw mid reset", BG_COLOR_ADDR, COLOR_RST);
  endtask : reset_again

  initial begin
    repeat (3) @(posedge CORE_CLK);
    SRST <= 1'b0;
    reset_values;
    pitch_fields;
    colour_formats;
    refused_places;
    reset_again;
    conclude;
  end

  initial begin
    #20000;
    errors++;
    conclude;
  end
endmodule : blit_pitch_and_color_regs_bench
